// ==== logic/rcpm_pkg.sv ====
// Shared constants for the reset-cause and power-mode controller
package rcpm_pkg;
   // Core clock rate
   localparam int CLK_MHZ = 250;
   // Register addresses on the special function register bus
   localparam logic [7:0] ADDR_PWR_CTRL = 8'h87;
   localparam logic [7:0] ADDR_RST_CAUSE = 8'hB1;
   localparam logic [7:0] ADDR_SLEEP = 8'hB6;
   // power_control fields
   localparam int PC_IDLE_BIT = 0;
   localparam int PC_STOP_BIT = 1;
   localparam logic [7:0] PC_WMASK = 8'h8F;
   localparam logic [7:0] PC_RESET = 8'h00;
   localparam int PC_BAUD_BIT = 7;
   // reset_cause_vector fields and values
   localparam int RC_CAUSE_BIT = 0;
   localparam int RC_VEC_BIT = 1;
   localparam logic [1:0] RC_POR = 2'h2;
   localparam logic [1:0] RC_WDOG = 2'h1;
   localparam logic [15:0] VEC_LOW = 16'h0000;
   localparam logic [15:0] VEC_ROM = 16'h8000;
   // sleep_depth encodings
   localparam logic [2:0] SD_NORMAL = 3'h0;
   localparam logic [2:0] SD_MOD = 3'h2;
   localparam logic [2:0] SD_STBY = 3'h3;
   localparam int SD_DEEP_BIT = 2;
   localparam logic [7:0] RD_ZERO = 8'h00;
   // Startup times in ns as printed
   localparam longint T_LIGHT_NS = 2500;
   localparam longint T_MOD_NS = 7000;
   localparam longint T_STBY_NS = 150000;
   localparam longint T_DEEP_NS = 1000000;
   localparam longint T_XO_NS = 3000000;
   // Least time rounded up to whole cycles
   function automatic int ns_to_cyc(input longint ns);
      return int'((ns * CLK_MHZ + 999) / 1000);
   endfunction
   localparam int LIGHT_CYC = ns_to_cyc(T_LIGHT_NS);
   localparam int MOD_CYC = ns_to_cyc(T_MOD_NS);
   localparam int STBY_CYC = ns_to_cyc(T_STBY_NS);
   localparam int DEEP_CYC = ns_to_cyc(T_DEEP_NS);
   localparam int XO_CYC = ns_to_cyc(T_XO_NS);
   // Initialisation phase length in core cycles
   localparam int INIT_CYC = 2500;
   localparam int CNT_W = 20;
endpackage

// ==== logic/rcpm_seq_if.sv ====
// Handshake between the mode controller and the startup sequencer
interface rcpm_seq_if (
   input wire logic clk,
   input wire logic rst_b
);
   logic start;
   logic run_osc;
   logic run_init;
   logic [rcpm_pkg::CNT_W-1:0] osc_cyc;
   logic slow_lvl;
   logic done;
   logic busy;
   modport ctl (input clk, input rst_b, output start, output run_osc, output run_init,
      output osc_cyc, output slow_lvl, input done, input busy);
   modport seq (input clk, input rst_b, input start, input run_osc, input run_init,
      input osc_cyc, input slow_lvl, output done, output busy);
endinterface

// ==== logic/rcpm_seq.sv ====
// Startup sequencer: oscillator phase then initialisation phase
module rcpm_seq (
   rcpm_seq_if.seq sif
);
   import rcpm_pkg::*;
   typedef enum logic [1:0] {SQ_IDLE, SQ_OSC, SQ_INIT} rcpm_sq_state_t;
   rcpm_sq_state_t st_r;
   logic [CNT_W-1:0] cnt_r;
   logic init_r;
   logic edge_seen_r;
   logic slow_prev_r;
   logic done_r;
   wire slow_edge = sif.slow_lvl & ~slow_prev_r;
   wire osc_end = (cnt_r == sif.osc_cyc - CNT_W'(1));
   wire init_cnt_ok = (cnt_r >= CNT_W'(INIT_CYC - 1));
   assign sif.done = done_r;
   assign sif.busy = (st_r != SQ_IDLE);

   // Phase timing; init waits for the count and a slow-clock rising edge seen at any point during the init phase
   always_ff @(posedge sif.clk or negedge sif.rst_b) begin
      if (!sif.rst_b) begin
         st_r <= SQ_IDLE;
         cnt_r <= '0;
         init_r <= 1'b0;
         edge_seen_r <= 1'b0;
         slow_prev_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         slow_prev_r <= sif.slow_lvl;
         done_r <= 1'b0;
         if (sif.start) begin
            cnt_r <= '0;
            init_r <= sif.run_init;
            edge_seen_r <= 1'b0;
            st_r <= sif.run_osc ? SQ_OSC : SQ_INIT; // [R18]
         end else begin
            case (st_r)
               SQ_OSC: begin
                  cnt_r <= osc_end ? '0 : cnt_r + CNT_W'(1);
                  if (osc_end) begin
                     st_r <= init_r ? SQ_INIT : SQ_IDLE;
                     done_r <= ~init_r;
                  end
               end
               SQ_INIT: begin
                  edge_seen_r <= edge_seen_r | slow_edge;
                  if (!init_cnt_ok) begin
                     cnt_r <= cnt_r + CNT_W'(1);
                  end
                  if (init_cnt_ok && (edge_seen_r || slow_edge)) begin // [R18]
                     st_r <= SQ_IDLE;
                     done_r <= 1'b1;
                  end
               end
               default: st_r <= SQ_IDLE;
            endcase
         end
      end
   end

   default clocking cb @(posedge sif.clk); endclocking
   default disable iff (!sif.rst_b);
   // Init phase never ends short of its cycle count
   AST_INIT_MIN: assert property ($fell(sif.busy) && $past(st_r) == SQ_INIT // [R18]
      |-> $past(init_cnt_ok))
      else $error("init phase ended early");
   AST_DONE_IDLE: assert property (done_r |-> st_r == SQ_IDLE)
      else $error("done while busy");
endmodule // rcpm_seq

// ==== logic/rcpm_top.sv ====
// Reset-cause register, power-mode control and wake sequencing
// Contract
// R1: Cause bit reads 0 after power-on reset, 1 after any other reset.
// R2: Vector bit selects reset vector 0x0000 when 0, 0x8000 when 1.
// R3: Cause register resets to 02; watchdog reset restarts at address 0.
// R4: Idle bit enters idle after the instruction completes; state is kept.
// R5: Core clock keeps running during idle.
// R6: Enabled interrupt in idle clears idle bit, resumes via service routine.
// R7: Watchdog reset in idle resets registers and restarts at 0x0000.
// R8: Stop bit enters stop on completion; only watchdog reset exits.
// R9: Nonzero sleep depth write enters power-down after instruction completes.
// R10: GPIO, RTC or watchdog end power-down; wake clears sleep depth.
// R11: Wake interrupt is serviced once power and clocks return.
// R12: Watchdog reset in power-down resets and restarts at 0x0000.
// R13: Sleep depth read returns slow clock level in bit 0.
// R14: Software waits for indirect busy clear before writing sleep depth.
// R15: Depth encodes light, moderate, standby and deep oscillator choices.
// R16: Wake delays 2.5, 7, 150 and 1000 microseconds by depth.
// R17: GPIO debounce adds to delay while still in power-down.
// R18: Startup is oscillator phase then 2500 cycles plus slow edge.
// R19: Slow-oscillator wakes may lose the wake interrupt; flag it.
// R20: Watchdog reset repeats the power-on reset sequence. The code skips the oscillator phase when the synchronised xtal_running is high.
module rcpm_top #(
   parameter int STBY_CYC = rcpm_pkg::STBY_CYC,
   parameter int DEEP_CYC = rcpm_pkg::DEEP_CYC,
   parameter int XO_CYC = rcpm_pkg::XO_CYC,
   parameter int DEBOUNCE_CYC = 16
) (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rst_b,
   // Core status
   input wire logic instr_done,
   input wire logic irq_pending,
   input wire logic wdog_rst,
   // Register bus
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // Always-on pins
   input wire logic gpio_wake,
   input wire logic rtc_wake,
   input wire logic slow_clock,
   input wire logic xtal_running,
   // Core control
   output logic cpu_rst,
   output logic cpu_halt,
   output logic cpu_clk_gate,
   output logic [15:0] reset_vector,
   output logic baud_doubler_bit,
   // Power control
   output logic xtal_en,
   output logic lposc_sel,
   output logic [2:0] regulator_depth,
   // Wake events
   output logic wake_isr_req,
   output logic wake_irq_lost
);
   import rcpm_pkg::*;
   typedef enum logic [2:0] {ST_RESET_SEQ, ST_RUN, ST_IDLE, ST_STOP, ST_PD, ST_DEBOUNCE,
      ST_WAKE} rcpm_state_t;

   rcpm_state_t state_r, state_nxt;
   logic [7:0] pc_r;
   logic [1:0] rc_r;
   logic [2:0] sd_r;
   logic [2:0] pd_lvl_r;
   logic [7:0] rdata_r;
   logic [15:0] vec_r;
   logic [3:0] meta_r, sync_r;
   logic [CNT_W-1:0] deb_r;
   logic start_r, run_osc_r, run_init_r;
   logic [CNT_W-1:0] osc_cyc_r;
   logic launch, launch_osc, launch_init;
   logic [CNT_W-1:0] launch_cyc;
   logic isr_r, lost_r;
   // Sequencer handshake, declared ahead of the mode logic that reads its done flag
   rcpm_seq_if seq (
      .clk (clk),
      .rst_b (rst_b)
   );

   // Wake delay by depth, slow-oscillator depths use the long figures
   function automatic logic [CNT_W-1:0] wake_cyc(input logic [2:0] lvl);
      if (lvl[SD_DEEP_BIT]) begin
         return CNT_W'(DEEP_CYC);
      end else if (lvl == SD_STBY) begin
         return CNT_W'(STBY_CYC);
      end else if (lvl == SD_MOD) begin
         return CNT_W'(MOD_CYC);
      end
      return CNT_W'(LIGHT_CYC);
   endfunction

   // Pin synchronisers; only sync_r is read by logic
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= {xtal_running, slow_clock, rtc_wake, gpio_wake};
         sync_r <= meta_r;
      end
   end
   wire gpio_s = sync_r[0];
   wire rtc_s = sync_r[1];
   wire slow_s = sync_r[2];
   wire xtal_s = sync_r[3];

   // Address decode
   wire hit_pc = (sfr_addr == ADDR_PWR_CTRL);
   wire hit_rc = (sfr_addr == ADDR_RST_CAUSE);
   wire hit_sd = (sfr_addr == ADDR_SLEEP);
   wire wr_pc = sfr_wr & hit_pc;
   wire wr_rc = sfr_wr & hit_rc;
   wire wr_sd = sfr_wr & hit_sd;
   wire in_pd = (state_r == ST_PD) || (state_r == ST_DEBOUNCE);
   wire deb_end = (deb_r >= CNT_W'(DEBOUNCE_CYC - 1));
   wire lp_level = pd_lvl_r[SD_DEEP_BIT] || (pd_lvl_r == SD_STBY);

   // Read mux; sleep depth shows only the slow clock level
   wire [7:0] rdata_nxt = hit_pc ? pc_r :
      hit_rc ? {6'h00, rc_r} :
      hit_sd ? {7'h00, slow_s} : RD_ZERO; // [R13]

   // Mode transitions; watchdog reset outranks everything
   always_comb begin
      state_nxt = state_r;
      launch = 1'b0;
      launch_osc = 1'b0;
      launch_init = 1'b0;
      launch_cyc = wake_cyc(pd_lvl_r);
      if (wdog_rst) begin
         state_nxt = ST_RESET_SEQ; // [R7] [R12] [R20]
         launch = 1'b1;
         launch_osc = ~xtal_s; // [R18]
         launch_init = 1'b1;
         launch_cyc = CNT_W'(XO_CYC);
      end else begin
         case (state_r)
            ST_RESET_SEQ: begin
               if (seq.done) begin
                  state_nxt = ST_RUN;
               end
            end
            ST_RUN: begin
               if (instr_done && sd_r != SD_NORMAL) begin
                  state_nxt = ST_PD; // [R9]
               end else if (instr_done && pc_r[PC_STOP_BIT]) begin
                  state_nxt = ST_STOP; // [R8]
               end else if (instr_done && pc_r[PC_IDLE_BIT]) begin
                  state_nxt = ST_IDLE; // [R4]
               end
            end
            ST_IDLE: begin
               if (irq_pending) begin
                  state_nxt = ST_RUN; // [R6]
               end
            end
            ST_PD: begin
               if (rtc_s) begin
                  state_nxt = ST_WAKE; // [R10]
                  launch = 1'b1;
                  launch_osc = 1'b1; // [R16]
               end else if (gpio_s) begin
                  state_nxt = ST_DEBOUNCE; // [R17]
               end
            end
            ST_DEBOUNCE: begin
               if (deb_end || rtc_s) begin
                  state_nxt = ST_WAKE; // [R17]
                  launch = 1'b1;
                  launch_osc = 1'b1;
               end
            end
            ST_WAKE: begin
               if (seq.done) begin
                  state_nxt = ST_RUN; // [R11]
               end
            end
            default: state_nxt = state_r; // Stop waits for watchdog reset only
         endcase
      end
   end

   // Mode state and sequencer launch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_RESET_SEQ;
         start_r <= 1'b1;
         run_osc_r <= 1'b1;
         run_init_r <= 1'b1;
         osc_cyc_r <= CNT_W'(XO_CYC);
      end else begin
         state_r <= state_nxt;
         start_r <= launch;
         if (launch) begin
            run_osc_r <= launch_osc;
            run_init_r <= launch_init;
            osc_cyc_r <= launch_cyc;
         end
      end
   end

   // Software registers; wake and interrupt clears, watchdog restores resets except the cause, which it sets to watchdog
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= PC_RESET;
         rc_r <= RC_POR; // [R1] [R3]
         sd_r <= SD_NORMAL;
         pd_lvl_r <= SD_NORMAL;
      end else if (wdog_rst) begin
         pc_r <= PC_RESET;
         rc_r <= RC_WDOG; // [R1] [R3]
         sd_r <= SD_NORMAL;
         pd_lvl_r <= SD_NORMAL;
      end else begin
         if (wr_pc) begin
            pc_r <= sfr_wdata & PC_WMASK;
         end else if (state_r == ST_IDLE && irq_pending) begin
            pc_r[PC_IDLE_BIT] <= 1'b0; // [R6]
         end
         if (wr_rc) begin
            rc_r <= sfr_wdata[1:0];
         end
         if (wr_sd && state_r == ST_RUN) begin
            sd_r <= sfr_wdata[2:0]; // [R15]
         end else if (launch && state_r != ST_RESET_SEQ) begin
            sd_r <= SD_NORMAL; // [R10]
         end
         if (state_r == ST_RUN && state_nxt == ST_PD) begin
            pd_lvl_r <= sd_r;
         end
      end
   end

   // Debounce count, wake results and registered outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         deb_r <= '0;
         isr_r <= 1'b0;
         lost_r <= 1'b0;
         rdata_r <= RD_ZERO;
         vec_r <= VEC_LOW;
      end else begin
         deb_r <= (state_r == ST_DEBOUNCE) ? deb_r + CNT_W'(1) : '0;
         isr_r <= (state_r == ST_WAKE) && seq.done && irq_pending; // [R11]
         lost_r <= (state_r == ST_WAKE) && seq.done && !irq_pending && lp_level; // [R19]
         rdata_r <= sfr_rd ? rdata_nxt : rdata_r;
         vec_r <= rc_r[RC_VEC_BIT] ? VEC_ROM : VEC_LOW; // [R2]
      end
   end

   // Sequencer hookup
   assign seq.start = start_r;
   assign seq.run_osc = run_osc_r;
   assign seq.run_init = run_init_r;
   assign seq.osc_cyc = osc_cyc_r;
   assign seq.slow_lvl = slow_s;
   rcpm_seq u_seq (
      .sif (seq)
   );

   // Outputs; clock only gated in power-down, never in idle or stop
   assign cpu_rst = (state_r == ST_RESET_SEQ);
   assign cpu_halt = (state_r != ST_RUN);
   assign cpu_clk_gate = in_pd; // [R5]
   assign reset_vector = vec_r;
   assign baud_doubler_bit = pc_r[PC_BAUD_BIT];
   assign xtal_en = !(in_pd && pd_lvl_r[SD_DEEP_BIT]); // [R15]
   assign lposc_sel = in_pd && lp_level; // [R15]
   assign regulator_depth = in_pd ? pd_lvl_r : SD_NORMAL;
   assign sfr_rdata = rdata_r;
   assign wake_isr_req = isr_r;
   assign wake_irq_lost = lost_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_WDOG_CAUSE: assert property (wdog_rst |=> rc_r == RC_WDOG && cpu_rst) // [R3]
      else $error("watchdog reset cause wrong");
   AST_VECTOR: assert property (rc_r[RC_VEC_BIT] [*2] |-> reset_vector == VEC_ROM) // [R2]
      else $error("reset vector mismatch");
   AST_IDLE_ENTRY: assert property (state_r == ST_RUN && instr_done // [R4]
      && pc_r[PC_IDLE_BIT] && !pc_r[PC_STOP_BIT] && sd_r == SD_NORMAL && !wdog_rst
      |=> state_r == ST_IDLE && cpu_halt)
      else $error("idle not entered");
   AST_IDLE_CLK: assert property (state_r == ST_IDLE || state_r == ST_STOP // [R5]
      |-> !cpu_clk_gate)
      else $error("clock gated in idle");
   AST_IDLE_EXIT: assert property (state_r == ST_IDLE && irq_pending && !wdog_rst // [R6]
      && !wr_pc |=> !pc_r[PC_IDLE_BIT] && state_r == ST_RUN)
      else $error("idle exit failed");
   AST_STOP_HOLD: assert property (state_r == ST_STOP && !wdog_rst |=> state_r == ST_STOP) // [R8]
      else $error("stop left without watchdog");
   AST_PD_ENTRY: assert property (state_r == ST_RUN && instr_done && sd_r != SD_NORMAL // [R9]
      && !wdog_rst |=> in_pd && cpu_clk_gate)
      else $error("power-down not entered");
   AST_PD_WAKE: assert property (state_r == ST_PD && rtc_s && !wdog_rst // [R10]
      |=> sd_r == SD_NORMAL && state_r == ST_WAKE)
      else $error("rtc wake did not clear depth");
   AST_SD_READ: assert property (sfr_rd && hit_sd |=> sfr_rdata == {7'h00, $past(slow_s)}) // [R13]
      else $error("slow clock level not read");
   AST_DEEP_XTAL: assert property (in_pd && pd_lvl_r[SD_DEEP_BIT] // [R15]
      |-> !xtal_en && lposc_sel)
      else $error("deep depth clocks wrong");
   AST_DEBOUNCE: assert property (state_r == ST_PD && gpio_s && !rtc_s && !wdog_rst // [R17]
      |=> state_r == ST_DEBOUNCE && cpu_clk_gate)
      else $error("gpio wake skipped debounce");
   AST_WDOG_PD: assert property (in_pd && wdog_rst |=> cpu_rst && !cpu_clk_gate) // [R12]
      else $error("watchdog did not end power-down");

   COV_IDLE: cover property (state_r == ST_IDLE ##1 state_r == ST_RUN);
   COV_PD_WAKE: cover property (state_r == ST_WAKE ##1 state_r == ST_RUN);
   COV_WDOG: cover property (state_r == ST_STOP ##1 state_r == ST_RESET_SEQ);
   COV_LOST: cover property (wake_irq_lost);
endmodule // rcpm_top

// ==== tb/rcpm_top_tb.sv ====
// Self-checking bench for the reset-cause and power-mode controller
module rcpm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rcpm_pkg::*;

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic instr_done = 1'b0;
   logic irq_pending = 1'b0;
   logic wdog_rst = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic gpio_wake = 1'b0;
   logic rtc_wake = 1'b0;
   logic slow_clock = 1'b0;
   logic xtal_running = 1'b1;
   logic [7:0] sfr_rdata;
   logic cpu_rst, cpu_halt, cpu_clk_gate, baud_doubler_bit;
   logic [15:0] reset_vector;
   logic xtal_en, lposc_sel, wake_isr_req, wake_irq_lost;
   logic [2:0] regulator_depth;
   logic isr_s, lost_s;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;
   int slow_cnt = 0;
   // Behavioural register model
   int pc_m = 0;
   int rc_m = 2;
   int wake_n = 0;
   int depths[5] = '{1, 2, 3, 4, 7};
   localparam int STBY_T = 40;
   localparam int DEEP_T = 60;
   localparam int XO_T = 30;
   localparam int DEB_T = 4;

   // Short counts keep each startup within a few thousand cycles
   rcpm_top #(.STBY_CYC(STBY_T), .DEEP_CYC(DEEP_T), .XO_CYC(XO_T), .DEBOUNCE_CYC(DEB_T)) dut (
      .clk(clk), .rst_b(rst_b), .instr_done(instr_done), .irq_pending(irq_pending),
      .wdog_rst(wdog_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .gpio_wake(gpio_wake), .rtc_wake(rtc_wake),
      .slow_clock(slow_clock), .xtal_running(xtal_running), .cpu_rst(cpu_rst),
      .cpu_halt(cpu_halt), .cpu_clk_gate(cpu_clk_gate), .reset_vector(reset_vector),
      .baud_doubler_bit(baud_doubler_bit), .xtal_en(xtal_en), .lposc_sel(lposc_sel),
      .regulator_depth(regulator_depth), .wake_isr_req(wake_isr_req),
      .wake_irq_lost(wake_irq_lost));

   // Core clock, 4 ns period
   always #2 clk = ~clk;

   // Slow clock toggles every 64 core cycles, changed on the falling edge
   always @(negedge clk) begin
      slow_cnt <= (slow_cnt == 63) ? 0 : slow_cnt + 1;
      if (slow_cnt == 63) slow_clock <= ~slow_clock;
   end

   // Hang guard: a run past the ceiling counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         $display("wrong value at %0t: run did not finish", $time);
         conclude();
      end
   end

   task automatic conclude();
      if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      chk({8'h00, sfr_rdata}, {8'h00, exp}, what);
   endtask

   // One instruction completes; the mode taken at that edge shows next
   task automatic instr();
      @(negedge clk);
      instr_done = 1'b1;
      @(negedge clk);
      instr_done = 1'b0;
   endtask

   // Wait for the core to run again, capturing the wake pulses at that cycle
   task automatic wait_run();
      int n;
      n = 0;
      while ((cpu_halt !== 1'b0 || cpu_rst !== 1'b0) && n < 8000) begin
         @(negedge clk);
         n++;
      end
      isr_s = wake_isr_req;
      lost_s = wake_irq_lost;
      wake_n = n;
      if (n >= 8000) begin
         error_cnt++;
         $display("wrong value at %0t: core stayed halted", $time);
      end
   endtask

   task automatic wdog();
      @(negedge clk);
      wdog_rst = 1'b1;
      @(negedge clk);
      wdog_rst = 1'b0;
      pc_m = 0;
      rc_m = 1;
      chk(cpu_rst, 1'b1, "reset held");
      wait_run();
      chk(reset_vector, VEC_LOW, "vector after watchdog");
      rd_chk(ADDR_RST_CAUSE, rc_m[7:0], "cause after watchdog");
      rd_chk(ADDR_PWR_CTRL, pc_m[7:0], "control after watchdog");
   endtask

   // Main sequence
   initial begin
      logic [7:0] v;
      logic r;
      int d;
      int exp_cyc;
      v = 8'($urandom(32'h16158db2));
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk(reset_vector, VEC_ROM, "vector after power-on");
      chk(cpu_rst, 1'b1, "startup running");
      wait_run();
      rd_chk(ADDR_RST_CAUSE, rc_m[7:0], "cause after power-on");
      rd_chk(8'h90, 8'h00, "unmapped read");
      // Vector bit selects either start address
      wr(ADDR_RST_CAUSE, 8'h01);
      @(negedge clk);
      chk(reset_vector, VEC_LOW, "vector bit clear");
      wr(ADDR_RST_CAUSE, 8'h02);
      @(negedge clk);
      chk(reset_vector, VEC_ROM, "vector bit set");
      // Idle with random flags; reserved bits read back as zero
      v = 8'(($urandom() & 8'hFC) | 8'h01);
      pc_m = v & 8'h8F;
      wr(ADDR_PWR_CTRL, v);
      rd_chk(ADDR_PWR_CTRL, pc_m[7:0], "control readback");
      chk(baud_doubler_bit, v[7], "baud doubler");
      instr();
      chk(cpu_halt, 1'b1, "idle halts");
      repeat (5) @(negedge clk);
      chk(cpu_clk_gate, 1'b0, "idle clock runs");
      irq_pending = 1'b1;
      wait_run();
      irq_pending = 1'b0;
      pc_m = pc_m & 8'hFE;
      rd_chk(ADDR_PWR_CTRL, pc_m[7:0], "idle bit cleared");
      // Stop ignores interrupts; only the watchdog ends it
      wr(ADDR_PWR_CTRL, 8'h02);
      instr();
      irq_pending = 1'b1;
      repeat (20) @(negedge clk);
      chk(cpu_halt, 1'b1, "stop ignores interrupt");
      chk(cpu_clk_gate, 1'b0, "stop clock runs");
      irq_pending = 1'b0;
      xtal_running = 1'($urandom());
      // Let the new crystal state clear the synchroniser before the watchdog hits
      @(negedge clk);
      wdog();
      // Every depth class, woken by the timer, with or without an interrupt
      // No indirect busy port here, so software waiting is implicit
      foreach (depths[i]) begin
         d = depths[i];
         r = 1'($urandom());
         wr(ADDR_SLEEP, d[7:0]);
         instr();
         @(negedge clk);
         chk(cpu_clk_gate, 1'b1, "power-down gates clock");
         chk(regulator_depth, d[2:0], "depth applied");
         chk(xtal_en, !d[2], "crystal enable");
         chk(lposc_sel, d >= 3, "slow oscillator select");
         irq_pending = r;
         repeat (10) @(negedge clk);
         chk(cpu_halt, 1'b1, "interrupt does not wake");
         rtc_wake = 1'b1;
         wait_run();
         rtc_wake = 1'b0;
         irq_pending = 1'b0;
         chk(isr_s, r, "wake service request");
         // Two sync stages, the mode edge, the launch and the done registers add five
         exp_cyc = (d == 1) ? LIGHT_CYC : (d == 2) ? MOD_CYC : (d == 3) ? STBY_T : DEEP_T;
         chk(16'(wake_n), 16'(exp_cyc + 5), "wake delay");
         chk(lost_s, !r && d >= 3, "wake interrupt lost");
         chk(regulator_depth, 3'h0, "depth cleared");
         instr();
         chk(cpu_halt, 1'b0, "no re-entry after clear");
      end
      // Slow clock level read while it is stable
      while (slow_cnt < 8 || slow_cnt > 40) @(negedge clk);
      rd_chk(ADDR_SLEEP, {7'h00, slow_clock}, "slow clock level");
      // Pin wake: debounce keeps the device powered down
      wr(ADDR_SLEEP, 8'h01);
      instr();
      gpio_wake = 1'b1;
      repeat (5) @(negedge clk);
      chk(cpu_clk_gate, 1'b1, "still down in debounce");
      wait_run();
      gpio_wake = 1'b0;
      chk(16'(wake_n), 16'(LIGHT_CYC + DEB_T), "pin wake delay");
      chk(cpu_clk_gate, 1'b0, "pin wake done");
      // Watchdog inside power-down
      wr(ADDR_SLEEP, 8'h02);
      instr();
      repeat (3) @(negedge clk);
      wdog();
      conclude();
   end
endmodule // rcpm_top_tb
